// File: pkg/uart_fifo_ctl_pkg.sv
package uart_fifo_ctl_pkg;

  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CHAR_W = 8;
  localparam int COUNT_W = 5;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_TX_DATA = 12'h008;

  // Control register fields
  localparam int CTL_FIFO_ENABLE = 0;
  localparam int CTL_RX_FLUSH = 1;
  localparam int CTL_TX_FLUSH = 2;
  localparam int CTL_DMA_STYLE = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Status register fields
  localparam int ST_RX_READY = 0;
  localparam int ST_TX_READY = 1;
  localparam int ST_DMA_ACTIVE = 2;
  localparam int ST_RX_COUNT_LSB = 8;
  localparam int ST_TX_COUNT_LSB = 16;

  // Fill levels reported by the character queues
  typedef struct packed {
    logic [COUNT_W-1:0] rx_count;
    logic [COUNT_W-1:0] tx_count;
    logic char_timeout;
  } fifo_levels_t;

  // State of the control block, apart from the transmit buffer
  typedef struct packed {
    logic [7:0] control;
    logic rx_dma_hold;
    logic rx_ready;
    logic tx_ready;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic slverr;
  } ctl_state_t;

  localparam ctl_state_t CTL_STATE_RESET = '{
    control: CONTROL_RESET,
    rx_dma_hold: 1'b0,
    rx_ready: 1'b0,
    tx_ready: 1'b0,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0
  };

endpackage

// File: rtl/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] data;
    logic [1:0] valid;
  } buf_state_t;

  buf_state_t state;
  buf_state_t next_state;
  logic slot;

  always_comb begin
    next_state = state;
    slot = 1'b0;
    if (state.valid[0] && out_ready) begin
      next_state.data[0] = state.data[1];
      next_state.valid[0] = state.valid[1];
      next_state.valid[1] = 1'b0;
    end
    if (in_valid && !state.valid[1]) begin
      slot = next_state.valid[0];
      next_state.data[slot] = in_data;
      next_state.valid[slot] = 1'b1;
    end
    if (flush) begin
      next_state.valid = 2'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Head entry drives the output directly
  assign out_data = state.data[0];
  assign out_valid = state.valid[0];
  assign in_ready = !state.valid[1];

endmodule

// File: rtl/uart_fifo_dma_ready_control.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - With queues enabled, the DMA style bit picks single or block request signalling.
// - With queues disabled, the DMA style bit is ignored; single-buffer signalling.
// - Block style: receive request rises once receive fill reaches trigger level.
// - Block style: a character timeout also raises the receive request.
// - Block style: receive request falls only when the receive queue is empty.
// - Block style: transmit request high while any transmit location is free.
// - Single style: receive request high while receive queue holds a character.
// - Single style: receive request falls as soon as the receive queue empties.
// - Single style: transmit request high only while transmit queue is empty.
// - Single style: transmit request falls when a character enters the queue.
// - Writing one to transmit flush with the enable bit also one clears that queue; the bit clears itself.
// - Writing one to receive flush with the enable bit also one clears that queue; the bit clears itself.
module uart_fifo_dma_ready_control #(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [uart_fifo_ctl_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uart_fifo_ctl_pkg::DATA_W-1:0] pwdata,
  output logic [uart_fifo_ctl_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uart_fifo_ctl_pkg::fifo_levels_t fifo_levels,
  input wire logic [uart_fifo_ctl_pkg::COUNT_W-1:0] rx_trigger_level,
  output logic [uart_fifo_ctl_pkg::CHAR_W-1:0] tx_char_data,
  output logic tx_char_valid,
  input wire logic tx_char_ready,
  output logic rx_ready_request,
  output logic tx_ready_request,
  output logic rx_queue_flush,
  output logic tx_queue_flush,
  output logic fifo_enable_bit,
  output logic dma_style_select
);

  localparam logic [uart_fifo_ctl_pkg::COUNT_W-1:0] DEPTH_LEVEL =
    FIFO_DEPTH[uart_fifo_ctl_pkg::COUNT_W-1:0];

  uart_fifo_ctl_pkg::ctl_state_t state;
  uart_fifo_ctl_pkg::ctl_state_t next_state;

  logic access;
  logic commit;
  logic hit_control;
  logic hit_status;
  logic hit_tx_data;
  logic tx_stall;
  logic buf_in_valid;
  logic buf_in_ready;
  logic tx_load;
  logic dma_active;
  logic rx_empty;
  logic rx_level_hit;
  logic [uart_fifo_ctl_pkg::DATA_W-1:0] status_word;

  // Register address match
  function automatic logic addr_hit(
    input logic [uart_fifo_ctl_pkg::ADDR_W-1:0] addr,
    input logic [uart_fifo_ctl_pkg::ADDR_W-1:0] offset
  );
    addr_hit = (addr == offset);
  endfunction

  assign access = psel && penable;
  assign commit = access && state.ready;
  assign hit_control = addr_hit(paddr, uart_fifo_ctl_pkg::OFS_CONTROL);
  assign hit_status = addr_hit(paddr, uart_fifo_ctl_pkg::OFS_STATUS);
  assign hit_tx_data = addr_hit(paddr, uart_fifo_ctl_pkg::OFS_TX_DATA);
  assign tx_stall = pwrite && hit_tx_data && !buf_in_ready;
  assign buf_in_valid = commit && pwrite && hit_tx_data;
  assign tx_load = tx_char_valid && tx_char_ready;
  assign dma_active = state.control[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE] &&
    state.control[uart_fifo_ctl_pkg::CTL_DMA_STYLE];
  assign rx_empty = (fifo_levels.rx_count == '0);
  assign rx_level_hit = (fifo_levels.rx_count >= rx_trigger_level);

  always_comb begin
    status_word = '0;
    status_word[uart_fifo_ctl_pkg::ST_RX_READY] = state.rx_ready;
    status_word[uart_fifo_ctl_pkg::ST_TX_READY] = state.tx_ready;
    status_word[uart_fifo_ctl_pkg::ST_DMA_ACTIVE] = dma_active;
    status_word[uart_fifo_ctl_pkg::ST_RX_COUNT_LSB +: uart_fifo_ctl_pkg::COUNT_W] =
      fifo_levels.rx_count;
    status_word[uart_fifo_ctl_pkg::ST_TX_COUNT_LSB +: uart_fifo_ctl_pkg::COUNT_W] =
      fifo_levels.tx_count;
  end

  always_comb begin
    next_state = state;
    // Flush bits last one cycle only
    next_state.control[uart_fifo_ctl_pkg::CTL_RX_FLUSH] = 1'b0;
    next_state.control[uart_fifo_ctl_pkg::CTL_TX_FLUSH] = 1'b0;

    // Bus response, one wait cycle then pready; a data write waits longer while the transmit buffer is full
    if (commit) begin
      next_state.ready = 1'b0;
      next_state.slverr = 1'b0;
    end else if (access && !state.ready && !tx_stall) begin
      next_state.ready = 1'b1;
      next_state.slverr = !(hit_control || hit_status || hit_tx_data);
      next_state.rdata = '0;
      if (!pwrite && hit_control) begin
        next_state.rdata[7:0] = {4'h0, state.control[3:0]};
      end else if (!pwrite && hit_status) begin
        next_state.rdata = status_word;
      end
    end

    // Control register write
    if (commit && pwrite && hit_control) begin
      next_state.control[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE] =
        pwdata[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE];
      if (pwdata[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE]) begin
        next_state.control[uart_fifo_ctl_pkg::CTL_DMA_STYLE] =
          pwdata[uart_fifo_ctl_pkg::CTL_DMA_STYLE];
        next_state.control[uart_fifo_ctl_pkg::CTL_RX_FLUSH] =
          pwdata[uart_fifo_ctl_pkg::CTL_RX_FLUSH];
        next_state.control[uart_fifo_ctl_pkg::CTL_TX_FLUSH] =
          pwdata[uart_fifo_ctl_pkg::CTL_TX_FLUSH];
      end
      // Switching the enable empties both queues
      if (pwdata[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE] !=
          state.control[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE]) begin
        next_state.control[uart_fifo_ctl_pkg::CTL_RX_FLUSH] = 1'b1;
        next_state.control[uart_fifo_ctl_pkg::CTL_TX_FLUSH] = 1'b1;
      end
    end

    // Block-style receive hold, set wins over empty
    next_state.rx_dma_hold = 1'b0;
    if (dma_active && !state.control[uart_fifo_ctl_pkg::CTL_RX_FLUSH]) begin
      next_state.rx_dma_hold = rx_level_hit || fifo_levels.char_timeout ||
        (state.rx_dma_hold && !rx_empty);
    end

    if (dma_active) begin
      next_state.rx_ready = next_state.rx_dma_hold;
      next_state.tx_ready = (fifo_levels.tx_count < DEPTH_LEVEL);
    end else begin
      next_state.rx_ready = !rx_empty;
      next_state.tx_ready = (fifo_levels.tx_count == '0) && !tx_load;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= uart_fifo_ctl_pkg::CTL_STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Transmit characters wait here until the queue accepts them
  two_entry_buffer #(
    .WIDTH(uart_fifo_ctl_pkg::CHAR_W)
  ) tx_stage (
    .clk(clk),
    .reset_n(reset_n),
    .flush(state.control[uart_fifo_ctl_pkg::CTL_TX_FLUSH]),
    .in_data(pwdata[uart_fifo_ctl_pkg::CHAR_W-1:0]),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .out_data(tx_char_data),
    .out_valid(tx_char_valid),
    .out_ready(tx_char_ready)
  );

  assign prdata = state.rdata;
  assign pready = state.ready;
  assign pslverr = state.slverr;
  assign rx_ready_request = state.rx_ready;
  assign tx_ready_request = state.tx_ready;
  assign rx_queue_flush = state.control[uart_fifo_ctl_pkg::CTL_RX_FLUSH];
  assign tx_queue_flush = state.control[uart_fifo_ctl_pkg::CTL_TX_FLUSH];
  assign fifo_enable_bit = state.control[uart_fifo_ctl_pkg::CTL_FIFO_ENABLE];
  assign dma_style_select = state.control[uart_fifo_ctl_pkg::CTL_DMA_STYLE];

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_dma_mode_pick:
    assert property (fifo_enable_bit && dma_style_select && rx_level_hit
      && !rx_queue_flush |=> rx_ready_request)
    else $error("block style not selected by style bit");

  a_disabled_single:
    assert property (!fifo_enable_bit && !rx_empty |=> rx_ready_request)
    else $error("style bit not ignored while queues disabled");

  a_dma_rx_trigger:
    assert property (dma_active && rx_level_hit && !rx_queue_flush
      |=> rx_ready_request)
    else $error("receive request missing at trigger level");

  a_dma_rx_timeout:
    assert property (dma_active && fifo_levels.char_timeout && !rx_queue_flush
      |=> rx_ready_request)
    else $error("receive request missing after timeout");

  a_dma_rx_hold:
    assert property (dma_active && $past(dma_active) && rx_ready_request && !rx_empty
      && !rx_queue_flush |=> rx_ready_request)
    else $error("receive request dropped before queue empty");

  a_dma_tx_space:
    assert property (dma_active && fifo_levels.tx_count < DEPTH_LEVEL
      |=> tx_ready_request)
    else $error("transmit request missing with free space");

  a_single_rx_level:
    assert property (!dma_active && !rx_empty |=> rx_ready_request)
    else $error("receive request missing with data present");

  a_single_rx_empty:
    assert property (!dma_active && rx_empty |=> !rx_ready_request)
    else $error("receive request held with empty queue");

  a_single_tx_busy:
    assert property (!dma_active && fifo_levels.tx_count != '0 |=> !tx_ready_request)
    else $error("transmit request with characters queued");

  a_single_tx_load:
    assert property (!dma_active && tx_load |=> !tx_ready_request)
    else $error("transmit request held across a load");

  a_tx_flush_self:
    assert property (commit && pwrite && hit_control && pwdata[0] && pwdata[2]
      |=> tx_queue_flush ##1 !tx_queue_flush && !tx_char_valid)
    else $error("transmit flush did not pulse and clear");

  a_rx_flush_self:
    assert property (commit && pwrite && hit_control && pwdata[0] && pwdata[1]
      |=> rx_queue_flush ##1 !rx_queue_flush)
    else $error("receive flush did not pulse once");

  a_enable_gate:
    assert property (commit && pwrite && hit_control && !pwdata[0] && !fifo_enable_bit
      |=> !rx_queue_flush && !tx_queue_flush && $stable(dma_style_select))
    else $error("control bits acted on without enable");

  a_apb_answer:
    assert property (access && !pready && !tx_stall |=> pready ##1 !pready)
    else $error("bus answer not given in one wait cycle");

  a_err_needs_ready:
    assert property (pslverr |-> pready)
    else $error("error flag without ready");

  a_unmapped_err:
    assert property (access && !pready && !tx_stall
      && !(hit_control || hit_status || hit_tx_data) |=> pslverr)
    else $error("unmapped address not flagged");

  a_mapped_no_err:
    assert property (access && !pready && (hit_control || hit_status || hit_tx_data)
      |=> !pslverr)
    else $error("error flag on a mapped register");

  a_control_read:
    assert property (access && !pready && !pwrite && hit_control
      |=> prdata[31:4] == 28'h0000000 && prdata[0] == $past(fifo_enable_bit)
      && prdata[3] == $past(dma_style_select))
    else $error("control read data wrong");

  a_status_read:
    assert property (access && !pready && !pwrite && hit_status
      |=> prdata[0] == $past(rx_ready_request) && prdata[1] == $past(tx_ready_request))
    else $error("status read data wrong");

  a_status_style:
    assert property (access && !pready && !pwrite && hit_status
      |=> prdata[2] == $past(fifo_enable_bit && dma_style_select))
    else $error("status style flag wrong");

  a_write_zero_data:
    assert property (access && !pready && !tx_stall && (pwrite || hit_tx_data)
      |=> prdata == 32'h0000_0000)
    else $error("read data not zero for write or data port");

  a_stall_waits:
    assert property (access && !pready && tx_stall |=> !pready)
    else $error("ready given while transmit buffer full");

  a_tx_word_accepted:
    assert property (commit && pwrite && hit_tx_data && !tx_queue_flush |=> tx_char_valid)
    else $error("written character not presented");

  a_tx_word_order:
    assert property (commit && pwrite && hit_tx_data && !tx_char_valid && !tx_queue_flush
      |=> tx_char_data == $past(pwdata[7:0]))
    else $error("written character not at buffer head");

  a_tx_head_holds:
    assert property (tx_char_valid && !tx_char_ready && !tx_queue_flush
      |=> tx_char_valid && $stable(tx_char_data))
    else $error("transmit head changed before it was taken");

  a_tx_flush_drops:
    assert property (tx_queue_flush |=> !tx_char_valid)
    else $error("buffered characters survived a transmit flush");

  a_enable_switch:
    assert property (commit && pwrite && hit_control && pwdata[0] != fifo_enable_bit
      |=> rx_queue_flush && tx_queue_flush)
    else $error("enable change did not flush both queues");

  a_enable_written:
    assert property (commit && pwrite && hit_control |=> fifo_enable_bit == $past(pwdata[0]))
    else $error("enable bit not taken from the write");

  a_style_ignored:
    assert property (commit && pwrite && hit_control && !pwdata[0]
      |=> $stable(dma_style_select))
    else $error("style bit taken without enable");

  a_flush_needs_write:
    assert property (!(commit && pwrite && hit_control)
      |=> !rx_queue_flush && !tx_queue_flush)
    else $error("flush pulse without a control write");

  a_single_tx_empty:
    assert property (!dma_active && fifo_levels.tx_count == '0 && !tx_load
      |=> tx_ready_request)
    else $error("transmit request missing with queue empty");

  a_dma_rx_drop:
    assert property (dma_active && rx_empty && !rx_level_hit
      && !fifo_levels.char_timeout |=> !rx_ready_request)
    else $error("receive request held after queue emptied");

  a_dma_tx_full:
    assert property (dma_active && fifo_levels.tx_count >= DEPTH_LEVEL |=> !tx_ready_request)
    else $error("transmit request with no free location");

  a_rx_flush_clear:
    assert property (dma_active && rx_queue_flush |=> !rx_ready_request)
    else $error("receive request survived a receive flush");

endmodule

// File: dv/queue_model.sv
`timescale 1ns/100ps
// Receive and transmit character queues behind the control block
module queue_model #(
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_pop,
  input wire logic stall,
  input wire logic timeout,
  input wire logic tx_char_valid,
  output logic tx_char_ready,
  input wire logic rx_queue_flush,
  input wire logic tx_queue_flush,
  output uart_fifo_ctl_pkg::fifo_levels_t fifo_levels
);
  logic [4:0] rx_count;
  logic [4:0] tx_count;
  assign tx_char_ready = !stall && tx_count < DEPTH;
  assign fifo_levels = '{rx_count: rx_count, tx_count: tx_count, char_timeout: timeout};
  always_ff @(posedge clk) begin
    if (!reset_n || rx_queue_flush) begin
      rx_count <= 5'h00;
    end else begin
      rx_count <= rx_count + 5'(rx_push) - 5'(rx_pop);
    end
    if (!reset_n || tx_queue_flush) begin
      tx_count <= 5'h00;
    end else begin
      tx_count <= tx_count + 5'(tx_char_valid && tx_char_ready) - 5'(tx_pop);
    end
  end
endmodule

// File: dv/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam logic [11:0] CTL = uart_fifo_ctl_pkg::OFS_CONTROL;
  localparam logic [11:0] STA = uart_fifo_ctl_pkg::OFS_STATUS;
  localparam logic [11:0] TXD = uart_fifo_ctl_pkg::OFS_TX_DATA;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, tx_char_valid, tx_char_ready;
  logic rx_req, tx_req, rx_fl, tx_fl, en, dma;
  logic rx_push = 0, rx_pop = 0, tx_pop = 0, stall = 0, tmo = 0;
  logic [4:0] trig = 5'h04;
  logic [7:0] tx_char_data;
  uart_fifo_ctl_pkg::fifo_levels_t lv;
  int failures = 0, compares = 0;
  always #25 clk = ~clk;
  uart_fifo_dma_ready_control #(.FIFO_DEPTH(4)) uart_fifo_dma_ready_control_inst (
    .clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_levels(lv), .rx_trigger_level(trig),
    .tx_char_data(tx_char_data), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .rx_ready_request(rx_req),
    .tx_ready_request(tx_req), .rx_queue_flush(rx_fl), .tx_queue_flush(tx_fl),
    .fifo_enable_bit(en), .dma_style_select(dma));
  queue_model #(.DEPTH(4)) queue_model_inst (
    .clk(clk), .reset_n(reset_n), .rx_push(rx_push), .rx_pop(rx_pop),
    .tx_pop(tx_pop), .stall(stall), .timeout(tmo), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .rx_queue_flush(rx_fl),
    .tx_queue_flush(tx_fl), .fifo_levels(lv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic rx_move(input int n, input logic up);
    @(posedge clk);
    if (up) rx_push <= 1;
    else rx_pop <= 1;
    repeat (n) @(posedge clk);
    rx_push <= 0; rx_pop <= 0;
  endtask
  task automatic settle;
    repeat (3) @(posedge clk);
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1;
    apb(0, CTL, 0); chk(rd, 0, "control reset");
    apb(0, 12'h010, 0); chk(err, 1, "unmapped");
    apb(1, CTL, 32'h8); apb(0, CTL, 0); chk(rd, 0, "bits without enable");
    rx_move(1, 1); settle; chk(rx_req, 1, "rx off mode");
    rx_move(1, 0);
    apb(1, CTL, 32'h9); settle; chk(dma, 1, "dma style");
    chk(en, 1, "enable set");
    chk(tx_req, 1, "tx block empty");
    rx_move(3, 1); settle; chk(rx_req, 0, "below trigger");
    rx_move(1, 1); settle; chk(rx_req, 1, "at trigger");
    rx_move(3, 0); settle; chk(rx_req, 1, "held");
    rx_move(1, 0); settle; chk(rx_req, 0, "emptied");
    rx_move(1, 1);
    tmo <= 1; @(posedge clk); tmo <= 0;
    settle; chk(rx_req, 1, "timeout");
    apb(1, CTL, 32'hb); @(posedge clk); chk(rx_fl, 1, "rx flush pulse");
    chk(tx_fl, 0, "tx flush idle");
    apb(0, CTL, 0); chk(rd, 32'h9, "rx flush clears");
    settle; chk(lv.rx_count, 0, "rx flushed");
    chk(rx_req, 0, "rx flushed req");
    stall <= 1;
    apb(1, TXD, 32'ha1); apb(1, TXD, 32'hb2); settle;
    chk(tx_char_valid, 1, "buffer held");
    chk(tx_char_data, 8'ha1, "buffer order");
    fork
      apb(1, TXD, 32'hc3);
      begin
        repeat (6) @(posedge clk);
        chk(pready, 0, "write waits on full buffer");
        chk(lv.tx_count, 0, "stalled queue");
        stall <= 0;
      end
    join
    apb(1, TXD, 32'hd4); settle;
    chk(lv.tx_count, 4, "tx full");
    chk(tx_req, 0, "tx full req");
    tx_pop <= 1; @(posedge clk); tx_pop <= 0;
    settle; chk(tx_req, 1, "tx one free");
    apb(1, CTL, 32'hd); @(posedge clk); chk(tx_fl, 1, "tx flush pulse");
    apb(0, CTL, 0); chk(rd, 32'h9, "tx flush clears");
    settle; chk(lv.tx_count, 0, "tx flushed");
    apb(1, CTL, 32'h1); settle; chk(dma, 0, "single style");
    chk(tx_req, 1, "tx empty");
    rx_move(1, 1); settle; chk(rx_req, 1, "rx one char");
    rx_move(1, 0); settle; chk(rx_req, 0, "rx empty");
    apb(1, TXD, 32'h5a); settle; chk(tx_req, 0, "tx loaded");
    tx_pop <= 1; @(posedge clk); tx_pop <= 0;
    settle; chk(tx_req, 1, "tx empty again");
    apb(0, STA, 0); chk(rd[2:0], 3'h2, "status");
    apb(1, CTL, 32'h9); apb(1, CTL, 32'h0); settle; chk(dma, 1, "style kept");
    chk(en, 0, "queues off");
    rx_move(1, 1); settle; chk(rx_req, 1, "style ignored when off");
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    close_out;
  end
endmodule
